// ---- rtl/pa_defs.svh ----
/*
 * Constants of the primitive assembly unit: widths, depths, reset values.
 * Assumes inclusion by the package and the verification files.
 */
`ifndef PA_DEFS_SVH
`define PA_DEFS_SVH

`define PA_VTX_W 16
`define PA_HIST 10
`define PA_MAX_PATCH 8
`define PA_PSIZE_W 4
`define PA_PSIZE_RESET 4'h3
`define PA_CNT_W 4
`define PA_CNT_SAT 4'hf
`define PA_GRP_W 3
`define PA_PVAL_W 8
`define PA_NV_W 4
`define PA_NV_SEG 4'h2
`define PA_NV_TRI 4'h3

`endif

// ---- rtl/pa_pkg.sv ----
/*
 * Types shared by the primitive assembly unit and its surroundings.
 * Assumes pa_defs.svh is on the include path.
 */
`include "pa_defs.svh"

package pa_pkg;

	typedef logic [`PA_VTX_W-1:0] pa_vtx_t;

	typedef enum logic [3:0] {
		md_seg_sep,
		md_seg_conn,
		md_tri_conn,
		md_tri_fan,
		md_tri_sep,
		md_seg_adj,
		md_segc_adj,
		md_tri_adj,
		md_tric_adj,
		md_patch
	} pa_mode_t;

	typedef enum logic [1:0] {
		pk_none,
		pk_seg,
		pk_tri,
		pk_patch
	} pa_kind_t;

	typedef struct packed {
		pa_kind_t kind;
		logic polygon;
		logic adj_valid;
		logic [`PA_NV_W-1:0] nvert;
		logic [`PA_MAX_PATCH-1:0][`PA_VTX_W-1:0] vtx;
		logic [2:0][`PA_VTX_W-1:0] adj;
	} pa_prim_t;

endpackage

// ---- rtl/pa_top.sv ----
/*
 * Primitive assembly: groups a vertex stream of one draw into segments,
 * triangles or patches, with optional neighbour vertices.
 * Assumes a vertex source and a primitive sink on the same clock; the sink
 * always accepts, draw_start/draw_end/vertices never share a cycle.
 */
`timescale 1ns/100ps

// Operation
// [R1] separate segments: pair consecutive vertices, drop odd last vertex
// [R2] separate segments keep one stored start vertex and a parity flag
// [R3] connected triangles: fewer than three vertices emit nothing
// [R4] connected triangles store alternately into A and B via toggling pointer
// [R5] each vertex after second emits A, B, current; first-triangle flag kept
// [R6] fan: every vertex after first overwrites B, A keeps first
// [R7] independent triangles from vertex triples, leftover one or two dropped
// [R8] independent triangles: A is group's first, B its second vertex
// [R9] segments with neighbours: groups of four, middle two drawn, tail dropped
// [R10] first and fourth of group are neighbours, dropped without geometry stage
// [R11] connected neighbour segments: segment i from vertex i+2 to i+3
// [R12] connected neighbour segments: fewer than four vertices discard all
// [R13] vertices i+1 and i+4 are neighbours, dropped without geometry stage
// [R14] triangles with neighbours: groups of six, vertices 1,3,5 form triangle
// [R15] vertices 2,4,6 neighbour edges 1-3,3-5,5-1; dropped without geometry
// [R16] connected neighbour triangles: n from 2(n+2)+k, single extra ignored
// [R17] connected neighbour triangles: fewer than six vertices discard all
// [R18] first triangle 1,3,5 with neighbours 2,7,4, or 2,6,4 if only
// [R19] later triangles follow even/odd ordering; last uses 2i+6 for 2i+7
// [R20] patch size set by command; zero, negative or over maximum rejected
// [R21] patches of v vertices in order, remainder dropped
// [R22] triangles tagged polygon, vertex order preserved
// [R23] connected segments: each later vertex ends previous and starts next
// [R24] all assembly state cleared at start of each draw
// [R25] end of draw pulses an indication, partial primitives dropped
module pa_top import pa_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic draw_start,
	input wire pa_mode_t draw_mode,
	input wire logic gs_active,
	input wire logic draw_end,
	input wire logic vtx_valid,
	input wire pa_vtx_t vtx_data,
	input wire logic set_patch_param_cmd,
	input wire logic signed [`PA_PVAL_W-1:0] patch_value,
	output logic prim_valid,
	output pa_prim_t prim,
	output logic draw_done,
	output logic err_invalid_value,
	output logic [`PA_PSIZE_W-1:0] patch_size
);

	pa_mode_t mode_r;
	logic gs_r;
	logic active_r;
	logic [`PA_HIST-1:0][`PA_VTX_W-1:0] hist_r;
	logic [`PA_HIST-1:0][`PA_VTX_W-1:0] hn;
	logic [`PA_HIST-1:0][`PA_VTX_W-1:0] hs;
	pa_vtx_t a_r, a_nxt;
	pa_vtx_t b_r, b_nxt;
	logic ptr_r, ptr_nxt;
	logic par_r, par_nxt;
	logic tdone_r, tdone_nxt;
	logic [`PA_GRP_W-1:0] grp_r, grp_nxt;
	logic [`PA_CNT_W-1:0] sat_r;
	logic [1:0] ph_r;
	logic [1:0] cn_ph;
	logic take;
	logic emit;
	pa_prim_t pn;
	logic [`PA_PSIZE_W-1:0] psize_r;
	logic [`PA_GRP_W-1:0] plast;

	function automatic pa_prim_t mk_seg(pa_vtx_t v0, pa_vtx_t v1, pa_vtx_t n0, pa_vtx_t n1, logic nv);
		pa_prim_t p;
		p = '0;
		p.kind = pk_seg;
		p.nvert = `PA_NV_SEG;
		p.vtx[0] = v0;
		p.vtx[1] = v1;
		p.adj[0] = n0;
		p.adj[1] = n1;
		p.adj_valid = nv;
		return p;
	endfunction

	function automatic pa_prim_t mk_tri(pa_vtx_t v0, pa_vtx_t v1, pa_vtx_t v2,
		pa_vtx_t n0, pa_vtx_t n1, pa_vtx_t n2, logic nv);
		pa_prim_t p;
		p = '0;
		p.kind = pk_tri;
		p.polygon = 1'b1; // R22
		p.nvert = `PA_NV_TRI;
		p.vtx[0] = v0;
		p.vtx[1] = v1;
		p.vtx[2] = v2;
		p.adj[0] = n0;
		p.adj[1] = n1;
		p.adj[2] = n2;
		p.adj_valid = nv;
		return p;
	endfunction

	assign take = vtx_valid && active_r;
	assign hn = {hist_r[`PA_HIST-2:0], vtx_data};
	assign hs = ph_r[0] ? {pa_vtx_t'(0), hist_r[`PA_HIST-1:1]} : hist_r; // R16
	assign cn_ph = ph_r + 2'h1;
	assign plast = `PA_GRP_W'(psize_r - `PA_PSIZE_W'(1));

	// assembly decisions per incoming vertex
	always_comb begin
		emit = 1'b0;
		pn = '0;
		a_nxt = a_r;
		b_nxt = b_r;
		ptr_nxt = ptr_r;
		par_nxt = par_r;
		tdone_nxt = tdone_r;
		grp_nxt = grp_r;
		if (take) begin
			unique case (mode_r)
				md_seg_sep: begin
					if (!par_r) begin
						a_nxt = vtx_data; // R2
					end else begin
						emit = 1'b1; // R1
						pn = mk_seg(a_r, vtx_data, '0, '0, 1'b0);
					end
					par_nxt = ~par_r; // R2
				end
				md_seg_conn: begin
					if (sat_r != '0) begin
						emit = 1'b1; // R23
						pn = mk_seg(a_r, vtx_data, '0, '0, 1'b0);
					end
					a_nxt = vtx_data; // R23
				end
				md_tri_conn: begin
					if (tdone_r || sat_r == `PA_CNT_W'(2)) begin
						emit = 1'b1; // R3
						pn = mk_tri(a_r, b_r, vtx_data, '0, '0, '0, 1'b0); // R5
						tdone_nxt = 1'b1; // R5
					end
					if (!ptr_r) begin
						a_nxt = vtx_data; // R4
					end else begin
						b_nxt = vtx_data; // R4
					end
					ptr_nxt = ~ptr_r; // R4
				end
				md_tri_fan: begin
					if (tdone_r || sat_r == `PA_CNT_W'(2)) begin
						emit = 1'b1; // R6
						pn = mk_tri(a_r, b_r, vtx_data, '0, '0, '0, 1'b0);
						tdone_nxt = 1'b1;
					end
					if (sat_r == '0) begin
						a_nxt = vtx_data; // R6
					end else begin
						b_nxt = vtx_data; // R6
					end
				end
				md_tri_sep: begin
					unique case (grp_r)
						`PA_GRP_W'(0): begin
							a_nxt = vtx_data; // R8
							grp_nxt = `PA_GRP_W'(1);
						end
						`PA_GRP_W'(1): begin
							b_nxt = vtx_data; // R8
							grp_nxt = `PA_GRP_W'(2);
						end
						default: begin
							emit = 1'b1; // R7
							pn = mk_tri(a_r, b_r, vtx_data, '0, '0, '0, 1'b0);
							tdone_nxt = 1'b1;
							grp_nxt = '0;
						end
					endcase
				end
				md_seg_adj: begin
					if (grp_r == `PA_GRP_W'(3)) begin
						emit = 1'b1; // R9
						pn = mk_seg(hn[2], hn[1], hn[3], hn[0], 1'b1); // R10
						grp_nxt = '0;
					end else begin
						grp_nxt = grp_r + `PA_GRP_W'(1);
					end
				end
				md_segc_adj: begin
					if (sat_r >= `PA_CNT_W'(3)) begin
						emit = 1'b1; // R12
						pn = mk_seg(hn[2], hn[1], hn[3], hn[0], 1'b1); // R11 R13
					end
				end
				md_tri_adj: begin
					if (grp_r == `PA_GRP_W'(5)) begin
						emit = 1'b1; // R14
						pn = mk_tri(hn[5], hn[3], hn[1], hn[4], hn[2], hn[0], 1'b1); // R15
						grp_nxt = '0;
					end else begin
						grp_nxt = grp_r + `PA_GRP_W'(1);
					end
				end
				md_tric_adj: begin
					// triangle i leaves when vertex 2i+8 shows it is not the last
					if (sat_r >= `PA_CNT_W'(7) && !cn_ph[0]) begin
						emit = 1'b1; // R17
						tdone_nxt = 1'b1;
						if (sat_r == `PA_CNT_W'(7)) begin
							pn = mk_tri(hn[7], hn[5], hn[3], hn[6], hn[1], hn[4], 1'b1); // R18
						end else if (cn_ph[1]) begin
							pn = mk_tri(hn[5], hn[7], hn[3], hn[9], hn[4], hn[1], 1'b1); // R19
						end else begin
							pn = mk_tri(hn[7], hn[5], hn[3], hn[9], hn[1], hn[4], 1'b1); // R19
						end
					end
				end
				md_patch: begin
					if (grp_r == plast) begin
						emit = 1'b1; // R21
						pn.kind = pk_patch;
						pn.nvert = psize_r;
						for (int j = 0; j < `PA_MAX_PATCH; j++) begin
							if (j < int'(psize_r)) begin
								pn.vtx[j] = hn[int'(plast) - j]; // R21
							end
						end
						grp_nxt = '0;
					end else begin
						grp_nxt = grp_r + `PA_GRP_W'(1);
					end
				end
				default: begin
					emit = 1'b0;
				end
			endcase
		end else if (draw_end && active_r && mode_r == md_tric_adj && sat_r >= `PA_CNT_W'(6)) begin
			// last triangle; hs drops a single extra trailing vertex
			emit = 1'b1; // R16
			tdone_nxt = 1'b1;
			if (sat_r <= `PA_CNT_W'(7)) begin
				pn = mk_tri(hs[5], hs[3], hs[1], hs[4], hs[0], hs[2], 1'b1); // R18
			end else if (!ph_r[1]) begin
				pn = mk_tri(hs[3], hs[5], hs[1], hs[7], hs[2], hs[0], 1'b1); // R19
			end else begin
				pn = mk_tri(hs[5], hs[3], hs[1], hs[7], hs[0], hs[2], 1'b1); // R19
			end
		end
	end

	// draw framing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			active_r <= 1'b0;
			mode_r <= md_seg_sep;
			gs_r <= 1'b0;
		end else if (draw_start) begin
			active_r <= 1'b1;
			mode_r <= draw_mode;
			gs_r <= gs_active;
		end else if (draw_end) begin
			active_r <= 1'b0; // R25
		end
	end

	// per-draw assembly state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hist_r <= '0;
			a_r <= '0;
			b_r <= '0;
			ptr_r <= 1'b0;
			par_r <= 1'b0;
			tdone_r <= 1'b0;
			grp_r <= '0;
			sat_r <= '0;
			ph_r <= '0;
		end else if (draw_start || draw_end) begin
			hist_r <= '0; // R24
			a_r <= '0; // R24
			b_r <= '0;
			ptr_r <= 1'b0; // R24
			par_r <= 1'b0;
			tdone_r <= 1'b0;
			grp_r <= '0; // R25
			sat_r <= '0;
			ph_r <= '0;
		end else if (take) begin
			hist_r <= hn;
			a_r <= a_nxt;
			b_r <= b_nxt;
			ptr_r <= ptr_nxt;
			par_r <= par_nxt;
			tdone_r <= tdone_nxt;
			grp_r <= grp_nxt;
			ph_r <= cn_ph;
			if (sat_r != `PA_CNT_SAT) begin
				sat_r <= sat_r + `PA_CNT_W'(1);
			end
		end
	end

	// primitive output
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prim_valid <= 1'b0;
			prim <= '0;
		end else begin
			prim_valid <= emit;
			if (emit) begin
				prim <= pn;
				if (!gs_r) begin
					prim.adj <= '0; // R10 R13 R15
					prim.adj_valid <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			draw_done <= 1'b0;
		end else begin
			draw_done <= draw_end && active_r; // R25
		end
	end

	// patch size command with range check
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			psize_r <= `PA_PSIZE_RESET; // R20
			err_invalid_value <= 1'b0;
		end else begin
			err_invalid_value <= 1'b0;
			if (set_patch_param_cmd) begin
				if (patch_value <= 0 || patch_value > `PA_MAX_PATCH) begin
					err_invalid_value <= 1'b1; // R20
				end else begin
					psize_r <= `PA_PSIZE_W'(patch_value); // R20
				end
			end
		end
	end

	assign patch_size = psize_r;

endmodule

// ---- verif/pa_assertions.sv ----
/*
 * Checker of the primitive assembly ports: draw framing, patch size, primitive shape.
 * Assumes one clock, async active-low reset, bound to every pa_top.
 */
`timescale 1ns/100ps
`include "pa_defs.svh"
module pa_checker import pa_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic draw_start,
	input wire pa_mode_t draw_mode,
	input wire logic gs_active,
	input wire logic draw_end,
	input wire logic vtx_valid,
	input wire pa_vtx_t vtx_data,
	input wire logic set_patch_param_cmd,
	input wire logic signed [`PA_PVAL_W-1:0] patch_value,
	input wire logic prim_valid,
	input wire pa_prim_t prim,
	input wire logic draw_done,
	input wire logic err_invalid_value,
	input wire logic [`PA_PSIZE_W-1:0] patch_size
);
	logic open_r;
	logic gs_r;
	// draw window and geometry stage of the open draw
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			open_r <= 1'b0;
			gs_r <= 1'b0;
		end else if (draw_start) begin
			open_r <= 1'b1;
			gs_r <= gs_active;
		end else if (draw_end) begin
			open_r <= 1'b0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_done_after_end: assert property (draw_end && open_r |=> draw_done)
		else $error("no done after draw end");
	a_done_cause: assert property (draw_done |-> $past(draw_end && open_r))
		else $error("done without draw end");
	a_err_reject: assert property (set_patch_param_cmd && (patch_value <= 0 || patch_value > `PA_MAX_PATCH)
		|=> err_invalid_value && $stable(patch_size)) else $error("bad patch value taken");
	a_size_load: assert property (set_patch_param_cmd && patch_value > 0 && patch_value <= `PA_MAX_PATCH
		|=> !err_invalid_value && patch_size == 4'($past(patch_value))) else $error("patch size not loaded");
	a_size_hold: assert property (!set_patch_param_cmd |=> $stable(patch_size))
		else $error("patch size moved");
	a_prim_cause: assert property (prim_valid |-> $past(open_r && (vtx_valid || draw_end)))
		else $error("primitive outside draw");
	a_tri_polygon: assert property (prim_valid && prim.kind == pk_tri |-> prim.polygon && prim.nvert == 4'h3)
		else $error("triangle shape wrong");
	a_seg_shape: assert property (prim_valid && prim.kind == pk_seg |-> !prim.polygon && prim.nvert == 4'h2)
		else $error("segment shape wrong");
	a_adj_gated: assert property (prim_valid && !gs_r |-> !prim.adj_valid && prim.adj == '0)
		else $error("neighbours without geometry stage");
	a_patch_count: assert property (prim_valid && prim.kind == pk_patch |-> prim.nvert == patch_size)
		else $error("patch length wrong");
endmodule

bind pa_top pa_checker u_chk (.clk(clk), .resetn(resetn), .draw_start(draw_start), .draw_mode(draw_mode),
	.gs_active(gs_active), .draw_end(draw_end), .vtx_valid(vtx_valid), .vtx_data(vtx_data),
	.set_patch_param_cmd(set_patch_param_cmd), .patch_value(patch_value), .prim_valid(prim_valid),
	.prim(prim), .draw_done(draw_done), .err_invalid_value(err_invalid_value), .patch_size(patch_size));

// ---- verif/pa_sink_model.sv ----
/*
 * Downstream stage model: takes every primitive and counts error pulses.
 * Assumes it shares the unit's clock and never stalls.
 */
`timescale 1ns/100ps
module pa_sink_model import pa_pkg::*; (
	input wire logic clk,
	input wire logic prim_valid,
	input wire pa_prim_t prim,
	input wire logic draw_done,
	input wire logic err_invalid_value
);
	pa_prim_t got[$];
	int n_err = 0;
	int n_done = 0;
	// sampled at the edge, so values are settled
	always @(posedge clk) begin
		if (prim_valid === 1'b1) got.push_back(prim);
		if (err_invalid_value === 1'b1) n_err++;
		if (draw_done === 1'b1) n_done++;
	end
endmodule

// ---- verif/tb_top.sv ----
/*
 * Self-checking bench: random draws of every mode against a queue model.
 * Assumes pa_top, the sink model and the bound checker.
 */
`timescale 1ns/100ps
`include "pa_defs.svh"
module tb_top import pa_pkg::*;;
	logic clk = 1'b0, resetn = 1'b0, draw_start = 1'b0, gs_active = 1'b0, draw_end = 1'b0;
	logic vtx_valid = 1'b0, set_patch_param_cmd = 1'b0, gs;
	pa_mode_t draw_mode = md_seg_sep;
	pa_vtx_t vtx_data = '0;
	logic signed [`PA_PVAL_W-1:0] patch_value = '0;
	logic prim_valid, draw_done, err_invalid_value;
	pa_prim_t prim;
	logic [`PA_PSIZE_W-1:0] patch_size;
	int bad_count = 0, n_compared = 0, cyc = 0, ps = 3, n_rej = 0, n_draws = 0, k, it;
	pa_vtx_t vv[0:15];
	pa_prim_t exp_q[$];
	pa_top u_dut (.clk(clk), .resetn(resetn), .draw_start(draw_start), .draw_mode(draw_mode),
		.gs_active(gs_active), .draw_end(draw_end), .vtx_valid(vtx_valid), .vtx_data(vtx_data),
		.set_patch_param_cmd(set_patch_param_cmd), .patch_value(patch_value), .prim_valid(prim_valid),
		.prim(prim), .draw_done(draw_done), .err_invalid_value(err_invalid_value), .patch_size(patch_size));
	pa_sink_model u_sink (.clk(clk), .prim_valid(prim_valid), .prim(prim), .draw_done(draw_done),
		.err_invalid_value(err_invalid_value));
	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic chk(input logic [191:0] g, input logic [191:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, g, e);
		end
	endtask
	task automatic conclude();
		if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
	endtask
	task automatic addp(input int a, b, c = 0, x = 0, y = 0, z = 0);
		pa_prim_t p;
		p = '0;
		p.kind = (c != 0) ? pk_tri : pk_seg;
		p.polygon = (c != 0);
		p.nvert = (c != 0) ? `PA_NV_TRI : `PA_NV_SEG;
		p.vtx[0] = vv[a];
		p.vtx[1] = vv[b];
		p.vtx[2] = vv[c];
		if (gs && x != 0) begin
			p.adj_valid = 1'b1;
			p.adj[0] = vv[x];
			p.adj[1] = vv[y];
			p.adj[2] = vv[z];
		end
		exp_q.push_back(p);
	endtask
	task automatic pcmd(input int val);
		set_patch_param_cmd <= 1'b1;
		patch_value <= `PA_PVAL_W'(val);
		tick();
		set_patch_param_cmd <= 1'b0;
		tick();
		if (val > 0 && val <= `PA_MAX_PATCH) ps = val;
		else n_rej++;
		chk(192'(patch_size), 192'(ps));
	endtask
	task automatic run(input pa_mode_t m, input int n);
		int i, j, nt;
		pa_prim_t g;
		gs = 1'($urandom);
		exp_q.delete();
		u_sink.got.delete();
		draw_start <= 1'b1;
		draw_mode <= m;
		gs_active <= gs;
		tick();
		draw_start <= 1'b0;
		for (i = 1; i <= n; i++) begin
			if (1'($urandom)) begin
				vtx_valid <= 1'b0;
				tick();
			end
			vv[i] = pa_vtx_t'($urandom);
			vtx_valid <= 1'b1;
			vtx_data <= vv[i];
			tick();
		end
		vtx_valid <= 1'b0;
		draw_end <= 1'b1;
		tick();
		draw_end <= 1'b0;
		vtx_valid <= 1'b1;
		vtx_data <= pa_vtx_t'($urandom);
		tick();
		vtx_valid <= 1'b0;
		tick(3);
		case (m)
			md_seg_sep: for (i = 2; i <= n; i += 2) addp(i - 1, i);
			md_seg_conn: for (i = 2; i <= n; i++) addp(i - 1, i);
			md_tri_conn: for (i = 3; i <= n; i++) if (i % 2) addp(i - 2, i - 1, i); else addp(i - 1, i - 2, i);
			md_tri_fan: for (i = 3; i <= n; i++) addp(1, i - 1, i);
			md_tri_sep: for (i = 3; i <= n; i += 3) addp(i - 2, i - 1, i);
			md_seg_adj: for (i = 4; i <= n; i += 4) addp(i - 2, i - 1, 0, i - 3, i);
			md_segc_adj: for (i = 4; i <= n; i++) addp(i - 2, i - 1, 0, i - 3, i);
			md_tri_adj: for (i = 6; i <= n; i += 6) addp(i - 5, i - 3, i - 1, i - 4, i - 2, i);
			md_tric_adj: begin
				nt = (n >= 6) ? (n - 4) / 2 : 0;
				for (i = 0; i < nt; i++) begin
					j = (i == nt - 1) ? 2 * i + 6 : 2 * i + 7;
					if (i == 0) addp(1, 3, 5, 2, j, 4);
					else if (i % 2) addp(2 * i + 3, 2 * i + 1, 2 * i + 5, 2 * i - 1, 2 * i + 4, j);
					else addp(2 * i + 1, 2 * i + 3, 2 * i + 5, 2 * i - 1, j, 2 * i + 4);
				end
			end
			md_patch: for (i = ps; i <= n; i += ps) begin
				g = '0;
				g.kind = pk_patch;
				g.nvert = `PA_NV_W'(ps);
				for (j = 0; j < ps; j++) g.vtx[j] = vv[i - ps + 1 + j];
				exp_q.push_back(g);
			end
			default: ;
		endcase
		chk(192'(u_sink.got.size()), 192'(exp_q.size()));
		foreach (exp_q[q]) if (q < u_sink.got.size()) begin
			chk(192'(u_sink.got[q]), 192'(exp_q[q]));
		end
		n_draws++;
		chk(192'(u_sink.n_done), 192'(n_draws));
	endtask
	initial begin
		void'($urandom(32'haf96e90a));
		vv[0] = '0;
		tick(20);
		resetn <= 1'b1;
		tick();
		chk(192'(patch_size), 192'(3));
		for (k = -2; k <= 10; k++) pcmd(k);
		pcmd(3);
		chk(192'(u_sink.n_err), 192'(n_rej));
		for (it = 0; it < 60; it++) begin
			if (it % 10 == 9) pcmd(1 + $urandom % 8);
			run(pa_mode_t'(it % 10), (it < 10) ? 6 : $urandom % 16);
		end
		// unused mode code emits nothing
		run(pa_mode_t'(4'ha), 6);
		conclude();
	end
endmodule
